/* File: iops_pkg.sv */
`default_nettype none
package iops_pkg;
    // Register byte offsets
    localparam logic [11:0] IOPS_CTRL_OFS = 12'h0000;
    localparam logic [11:0] IOPS_STATUS_OFS = 12'h0004;
    localparam logic [11:0] IOPS_CHAN_OFS = 12'h0008;
    // Control register fields and reset value
    localparam int IOPS_CTRL_EN_BIT = 0;
    localparam int IOPS_CTRL_ALT_CLR_BIT = 1;
    localparam logic [1:0] IOPS_CTRL_RST = 2'h1;
    // Status register field positions
    localparam int IOPS_ST_VALID_BIT = 0;
    localparam int IOPS_ST_UPPER_BIT = 1;
    localparam int IOPS_ST_ODD_BIT = 2;
    localparam int IOPS_ST_CHAN_LSB = 3;
    localparam int IOPS_ST_FUNC_LSB = 5;
    localparam int IOPS_ST_ALT_LSB = 7;
    localparam int IOPS_ST_PRES_LSB = 11;
    // Function flip-flop positions within a chassis
    localparam int IOPS_F_EI = 0;
    localparam int IOPS_F_EF = 1;
    localparam int IOPS_F_OD = 2;
    localparam int IOPS_F_ID = 3;
    // Chassis indices: two per drawer, odd chassis first
    localparam int IOPS_CH1 = 0;
    localparam int IOPS_CH2 = 1;
    localparam int IOPS_CH9 = 2;
    localparam int IOPS_CH10 = 3;
    // Function type codes {hi, lo}
    localparam logic [1:0] IOPS_TYPE_EI = 2'h0;
    localparam logic [1:0] IOPS_TYPE_EF = 2'h1;
    localparam logic [1:0] IOPS_TYPE_OD = 2'h2;
    localparam logic [1:0] IOPS_TYPE_ID = 2'h3;
    // Group decode positions
    localparam int IOPS_G_CH2 = 0;
    localparam int IOPS_G_CH1 = 1;
    localparam int IOPS_G_CH10 = 2;
    localparam int IOPS_G_CH9 = 3;
endpackage : iops_pkg
`default_nettype wire

/* File: iops_select.sv */
`default_nettype none
// How it works
// [RQ1] Per drawer, grant only the highest-numbered of eight channels with any request.
// [RQ2] Odd chassis first channel bit high for granted channel 5 or 7.
// [RQ3] Odd chassis second channel bit high for granted channel 3 or 7.
// [RQ4] Even chassis first channel bit high for granted channel 4 or 6.
// [RQ5] Even chassis second channel bit high for granted channel 2 or 6.
// [RQ6] Only granted channel enters; data in data scan, interrupts later if none.
// [RQ7] Type code: interrupt 00, function 01, output 10, input 11.
// [RQ8] Pending external interrupt beats every other type.
// [RQ9] Without interrupt, external function is chosen.
// [RQ10] Output data chosen when it alone remains pending.
// [RQ11] Without interrupt, input data chosen when it wins the out-in decision.
// [RQ12] Input wins if present and output was last; otherwise output first.
// [RQ13] Alternator sets on output-data or external-function acknowledge of chassis.
// [RQ14] Alternator clears on input-data acknowledge of same chassis.
// [RQ15] Each chassis drives a presence output beside its two type outputs.
// [RQ16] Group stage treats high presence as chassis holding a request.
// [RQ17] Group stage picks present chassis with higher channel numbers.
// [RQ18] Only chosen chassis channel and type reach the translators.
// [RQ19] Odd-group flop set at gate time when odd chassis chosen.
// [RQ20] Upper-group flop set at gate time when chassis 9 or 10 chosen.
// [RQ21] Presence flop set at same timing when any chassis holds a request.
// [RQ22] Four group decode outputs enabled only while presence flop is set; here they follow the flop one cycle late.
// [RQ23] Decode: 00 chassis 2, 01 chassis 1, 10 chassis 10, 11 chassis 9.
// [RQ24] Translator flops hold their selection until the sequence clears them.
module iops_select
    import iops_pkg::*;
(
    input wire logic clk_sys,
    input wire logic resetn,
    // APB slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // Peripheral requests, drawer 0 (chassis 1/2) and drawer 1 (9/10)
    input wire logic [7:0] ei_req_d0,
    input wire logic [7:0] ef_req_d0,
    input wire logic [7:0] od_req_d0,
    input wire logic [7:0] id_req_d0,
    input wire logic [7:0] ei_req_d1,
    input wire logic [7:0] ef_req_d1,
    input wire logic [7:0] od_req_d1,
    input wire logic [7:0] id_req_d1,
    // Sequence timing, same clock
    input wire logic data_scan,
    input wire logic intr_scan,
    input wire logic req_gate,
    input wire logic xlat_clear,
    input wire logic [3:0] od_ef_ack,
    input wire logic [3:0] id_ack,
    // Per-chassis function stage outputs
    output logic [3:0] function_type_hi_out,
    output logic [3:0] function_type_lo_out,
    output logic [3:0] chassis_request_present,
    output logic [1:0] odd_chan_sel_bit1,
    output logic [1:0] odd_chan_sel_bit0,
    output logic [1:0] even_chan_sel_bit1,
    output logic [1:0] even_chan_sel_bit0,
    output logic any_request_present,
    // Translators
    output logic odd_group_ff,
    output logic upper_group_ff,
    output logic selection_valid_ff,
    output logic [3:0] group_decode,
    output logic [1:0] chan_xlat,
    output logic [1:0] func_xlat
);
    import iops_pkg::*;

    // Highest set bit as one-hot
    function automatic logic [7:0] grant8(input logic [7:0] r);
        logic [7:0] g;
        g = 8'h00;
        for (int i = 0; i < 8; i++)
        begin
            if (r[i])
            begin
                g = 8'h00;
                g[i] = 1'b1;
            end
        end
        return g;
    endfunction

    // Type select: returns {present, hi, lo}
    // Lone input data is taken; a set alternator hands input the turn
    function automatic logic [2:0] sel_type(input logic [3:0] f,
                                            input logic alt);
        logic take_in;
        logic [1:0] code;
        take_in = f[IOPS_F_ID] & (~f[IOPS_F_OD] | alt);
        if (f[IOPS_F_EI])
            code = IOPS_TYPE_EI;
        else if (f[IOPS_F_EF])
            code = IOPS_TYPE_EF;
        else if (take_in)
            code = IOPS_TYPE_ID;
        else
            code = IOPS_TYPE_OD;
        return {|f, code};
    endfunction

    // Input synchronisers, two stages each
    logic [7:0] req_s1_r [8];
    logic [7:0] req_s2_r [8];
    logic [7:0] req_raw [8];
    assign req_raw[0] = ei_req_d0;
    assign req_raw[1] = ef_req_d0;
    assign req_raw[2] = od_req_d0;
    assign req_raw[3] = id_req_d0;
    assign req_raw[4] = ei_req_d1;
    assign req_raw[5] = ef_req_d1;
    assign req_raw[6] = od_req_d1;
    assign req_raw[7] = id_req_d1;

    always_ff @(posedge clk_sys)
    begin
        for (int k = 0; k < 8; k++)
        begin
            req_s1_r[k] <= resetn ? req_raw[k] : 8'h00;
            req_s2_r[k] <= resetn ? req_s1_r[k] : 8'h00;
        end
    end

    // Control register
    logic [1:0] ctrl_r;
    logic capture_en;
    assign capture_en = ctrl_r[IOPS_CTRL_EN_BIT];

    // Channel and function flip-flops
    logic [7:0] chan_ff_r [2];
    logic [3:0] func_ff_r [4];
    logic [3:0] alt_ff_r;

    // Scan request sets and grants per drawer
    logic [7:0] data_any [2];
    logic [7:0] data_gnt [2];
    logic [7:0] ei_gnt [2];
    logic [1:0] drawer_busy;
    genvar d;
    generate
        for (d = 0; d < 2; d++)
        begin : g_drw
            assign data_any[d] = req_s2_r[4*d+1] | req_s2_r[4*d+2]
                                 | req_s2_r[4*d+3];
            assign data_gnt[d] = grant8(data_any[d]); // RQ1
            assign ei_gnt[d] = grant8(req_s2_r[4*d]); // RQ1
            assign drawer_busy[d] = |func_ff_r[2*d] | |func_ff_r[2*d+1];
        end
    endgenerate

    // Scan capture; interrupts only when the drawer found no data request
    always_ff @(posedge clk_sys)
    begin
        for (int j = 0; j < 2; j++)
        begin
            if (!resetn || xlat_clear)
            begin
                chan_ff_r[j] <= 8'h00;
                func_ff_r[2*j] <= 4'h0;
                func_ff_r[2*j+1] <= 4'h0;
            end
            else if (capture_en && data_scan && !selection_valid_ff)
            begin
                chan_ff_r[j] <= data_gnt[j]; // RQ6
                for (int c = 0; c < 2; c++)
                begin
                    func_ff_r[2*j+c] <= {
                        |(req_s2_r[4*j+3] & data_gnt[j] & par_mask(c)),
                        |(req_s2_r[4*j+2] & data_gnt[j] & par_mask(c)),
                        |(req_s2_r[4*j+1] & data_gnt[j] & par_mask(c)),
                        1'b0}; // RQ6
                end
            end
            else if (capture_en && intr_scan && !drawer_busy[j]
                     && !selection_valid_ff)
            begin
                chan_ff_r[j] <= ei_gnt[j]; // RQ6
                for (int c = 0; c < 2; c++)
                begin
                    func_ff_r[2*j+c] <= {3'h0,
                        |(req_s2_r[4*j] & ei_gnt[j] & par_mask(c))}; // RQ6
                end
            end
        end
    end

    // Odd chassis owns odd channel bits, even chassis the even ones
    function automatic logic [7:0] par_mask(input int c);
        return (c == 0) ? 8'hAA : 8'h55;
    endfunction

    // Per-chassis type selection and channel encoding
    logic [2:0] typ [4];
    logic [1:0] chenc [4];
    generate
        for (d = 0; d < 4; d++)
        begin : g_chs
            assign typ[d] = sel_type(func_ff_r[d], alt_ff_r[d]); // RQ7 RQ8 RQ9 RQ10 RQ11 RQ12
        end
        for (d = 0; d < 2; d++)
        begin : g_enc
            assign chenc[2*d][1] = chan_ff_r[d][5] | chan_ff_r[d][7]; // RQ2
            assign chenc[2*d][0] = chan_ff_r[d][3] | chan_ff_r[d][7]; // RQ3
            assign chenc[2*d+1][1] = chan_ff_r[d][4] | chan_ff_r[d][6]; // RQ4
            assign chenc[2*d+1][0] = chan_ff_r[d][2] | chan_ff_r[d][6]; // RQ5
        end
    endgenerate

    // Alternators; set wins if both acknowledges coincide
    // The control clear bit overrides both acknowledges
    always_ff @(posedge clk_sys)
    begin
        if (!resetn || ctrl_r[IOPS_CTRL_ALT_CLR_BIT])
            alt_ff_r <= 4'h0;
        else
            alt_ff_r <= od_ef_ack | (alt_ff_r & ~id_ack); // RQ13 RQ14
    end

    // Group priority: 9 over 10 over 1 over 2
    logic [3:0] pres;
    logic any_pres;
    logic grp_upper;
    logic grp_odd;
    logic [1:0] sel_idx;
    assign pres = {typ[3][2], typ[2][2], typ[1][2], typ[0][2]}; // RQ16
    assign any_pres = |pres;
    assign grp_upper = pres[IOPS_CH9] | pres[IOPS_CH10]; // RQ17
    assign grp_odd = pres[IOPS_CH9]
                     | (pres[IOPS_CH1] & ~pres[IOPS_CH10]); // RQ17
    assign sel_idx = {grp_upper, ~grp_odd};

    // Chosen chassis feeds the translators, others are blocked
    logic [1:0] sel_chan;
    logic [1:0] sel_func;
    assign sel_chan = chenc[sel_idx]; // RQ18
    assign sel_func = typ[sel_idx][1:0]; // RQ18

    // Translator flops, captured once and held until cleared
    // Scans are refused meanwhile, so the decode cannot drift
    logic xlat_load;
    assign xlat_load = req_gate & any_pres & ~selection_valid_ff;

    always_ff @(posedge clk_sys)
    begin
        if (!resetn || xlat_clear)
        begin
            odd_group_ff <= 1'b0;
            upper_group_ff <= 1'b0;
            selection_valid_ff <= 1'b0;
            chan_xlat <= 2'h0;
            func_xlat <= 2'h0;
        end
        else if (xlat_load) // RQ24
        begin
            odd_group_ff <= grp_odd; // RQ19
            upper_group_ff <= grp_upper; // RQ20
            selection_valid_ff <= 1'b1; // RQ21
            chan_xlat <= sel_chan; // RQ18
            func_xlat <= sel_func; // RQ18
        end
    end

    // Group decode follows the held flops one cycle later
    logic [3:0] gdec_nxt;
    always_comb
    begin
        gdec_nxt = 4'h0;
        if (selection_valid_ff) // RQ22
            gdec_nxt[{upper_group_ff, odd_group_ff}] = 1'b1; // RQ23
    end

    // Registered copies of the function stage outputs
    always_ff @(posedge clk_sys)
    begin
        if (!resetn)
        begin
            group_decode <= 4'h0;
            function_type_hi_out <= 4'h0;
            function_type_lo_out <= 4'h0;
            chassis_request_present <= 4'h0;
            any_request_present <= 1'b0;
            odd_chan_sel_bit1 <= 2'h0;
            odd_chan_sel_bit0 <= 2'h0;
            even_chan_sel_bit1 <= 2'h0;
            even_chan_sel_bit0 <= 2'h0;
        end
        else
        begin
            group_decode <= gdec_nxt;
            for (int c = 0; c < 4; c++)
            begin
                function_type_hi_out[c] <= typ[c][1]; // RQ7
                function_type_lo_out[c] <= typ[c][0]; // RQ7
            end
            chassis_request_present <= pres; // RQ15
            any_request_present <= any_pres;
            odd_chan_sel_bit1 <= {chenc[IOPS_CH9][1], chenc[IOPS_CH1][1]};
            odd_chan_sel_bit0 <= {chenc[IOPS_CH9][0], chenc[IOPS_CH1][0]};
            even_chan_sel_bit1 <= {chenc[IOPS_CH10][1], chenc[IOPS_CH2][1]};
            even_chan_sel_bit0 <= {chenc[IOPS_CH10][0], chenc[IOPS_CH2][0]};
        end
    end

    // APB decode; one wait state keeps pready and prdata registered
    logic acc_phase;
    logic hit_ctrl;
    logic hit_status;
    logic hit_chan;
    logic hit_any;
    logic [31:0] rd_mux;
    assign acc_phase = psel & penable & ~pready;
    // Unmapped offsets answer with pslverr and drop writes
    assign hit_ctrl = (paddr == IOPS_CTRL_OFS);
    assign hit_status = (paddr == IOPS_STATUS_OFS);
    assign hit_chan = (paddr == IOPS_CHAN_OFS);
    assign hit_any = hit_ctrl | hit_status | hit_chan;

    always_comb
    begin
        rd_mux = 32'h0000_0000;
        if (hit_ctrl)
            rd_mux[1:0] = ctrl_r;
        else if (hit_status)
        begin
            rd_mux[IOPS_ST_VALID_BIT] = selection_valid_ff;
            rd_mux[IOPS_ST_UPPER_BIT] = upper_group_ff;
            rd_mux[IOPS_ST_ODD_BIT] = odd_group_ff;
            rd_mux[IOPS_ST_CHAN_LSB +: 2] = chan_xlat;
            rd_mux[IOPS_ST_FUNC_LSB +: 2] = func_xlat;
            rd_mux[IOPS_ST_ALT_LSB +: 4] = alt_ff_r;
            rd_mux[IOPS_ST_PRES_LSB +: 4] = pres;
        end
        else if (hit_chan)
            rd_mux[15:0] = {chan_ff_r[1], chan_ff_r[0]};
    end

    // Bus response flops
    always_ff @(posedge clk_sys)
    begin
        if (!resetn)
        begin
            pready <= 1'b0;
            pslverr <= 1'b0;
            prdata <= 32'h0000_0000;
        end
        else
        begin
            pready <= acc_phase;
            pslverr <= acc_phase & ~hit_any; // Unmapped address
            if (acc_phase && !pwrite)
                prdata <= rd_mux;
        end
    end

    // Writes land at the completing edge only
    always_ff @(posedge clk_sys)
    begin
        if (!resetn)
            ctrl_r <= IOPS_CTRL_RST;
        else if (psel && penable && pready && pwrite && hit_ctrl)
            ctrl_r <= pwdata[1:0];
    end

endmodule : iops_select
`default_nettype wire

/* File: iops_select_assertions.sv */
`default_nettype none
// Translator and bus checks, from the top ports only
module iops_select_assertions (
    input wire logic clk_sys,
    input wire logic resetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pready,
    input wire logic req_gate,
    input wire logic xlat_clear,
    input wire logic [3:0] chassis_request_present,
    input wire logic any_request_present,
    input wire logic odd_group_ff,
    input wire logic upper_group_ff,
    input wire logic selection_valid_ff,
    input wire logic [3:0] group_decode,
    input wire logic [1:0] chan_xlat,
    input wire logic [1:0] func_xlat
);
    timeunit 1ns;
    timeprecision 1ps;
    // One domain, so clock and reset are given once
    default clocking @(posedge clk_sys); endclocking
    default disable iff (!resetn);
    a_drawer_one: assert property (
        !(chassis_request_present[0] && chassis_request_present[1]) &&
        !(chassis_request_present[2] && chassis_request_present[3]))
        else $error("two chassis of one drawer present");
    a_decode_off: assert property (
        !$past(selection_valid_ff) |-> group_decode == 4'h0)
        else $error("decode active without selection");
    a_decode_map: assert property (
        $past(selection_valid_ff) |-> group_decode ==
        4'h1 << {$past(upper_group_ff), $past(odd_group_ff)})
        else $error("decode does not match flops");
    a_valid_cause: assert property (
        $rose(selection_valid_ff) |->
        $past(req_gate) && any_request_present)
        else $error("selection without gate or request");
    a_group_pick: assert property (
        $rose(selection_valid_ff) |->
        upper_group_ff == |chassis_request_present[3:2] &&
        odd_group_ff == (chassis_request_present[2] |
        (chassis_request_present[0] & ~chassis_request_present[3])))
        else $error("wrong chassis captured");
    a_xlat_hold: assert property (
        selection_valid_ff && !xlat_clear |=> $stable({selection_valid_ff,
        odd_group_ff, upper_group_ff, chan_xlat, func_xlat}))
        else $error("translator moved while held");
    a_xlat_clear: assert property (
        xlat_clear |=> !selection_valid_ff && !odd_group_ff && !upper_group_ff)
        else $error("translator not cleared");
    a_apb_wait: assert property (
        psel && penable && !pready |=> pready)
        else $error("bus answer late");
    a_ready_pulse: assert property (
        pready |=> !pready)
        else $error("ready longer than one cycle");
endmodule // iops_select_assertions
bind iops_select iops_select_assertions u_chk (.*);
`default_nettype wire

/* File: iops_periph.sv */
`default_nettype none
// Peripheral side: request levels held until the next post
module iops_periph (
    input wire logic clk_sys,
    output logic [7:0] ei_req_d0,
    output logic [7:0] ef_req_d0,
    output logic [7:0] od_req_d0,
    output logic [7:0] id_req_d0,
    output logic [7:0] ei_req_d1,
    output logic [7:0] ef_req_d1,
    output logic [7:0] od_req_d1,
    output logic [7:0] id_req_d1
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [63:0] req_r = 64'h0;
    // Levels change just after an edge, never mid-cycle
    assign {ei_req_d0, ef_req_d0, od_req_d0, id_req_d0} = req_r[63:32];
    assign {ei_req_d1, ef_req_d1, od_req_d1, id_req_d1} = req_r[31:0];
    task automatic post(input logic [63:0] v);
        @(posedge clk_sys);
        req_r <= v;
    endtask
endmodule // iops_periph
`default_nettype wire

/* File: iops_select_test.sv */
`default_nettype none
module iops_select_test;
    timeunit 1ns;
    timeprecision 1ps;
    import iops_pkg::*;
    logic clk_sys = 1'h0, resetn = 1'h0;
    logic psel = 1'h0, penable = 1'h0, pwrite = 1'h0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0000_0000;
    logic data_scan = 1'h0, intr_scan = 1'h0;
    logic req_gate = 1'h0, xlat_clear = 1'h0;
    logic [3:0] od_ef_ack = 4'h0, id_ack = 4'h0;
    logic [7:0] ei_req_d0, ef_req_d0, od_req_d0, id_req_d0;
    logic [7:0] ei_req_d1, ef_req_d1, od_req_d1, id_req_d1;
    logic [31:0] prdata, rd;
    logic pready, pslverr, any_request_present, er;
    logic [3:0] function_type_hi_out, function_type_lo_out;
    logic [3:0] chassis_request_present, group_decode;
    logic [1:0] odd_chan_sel_bit1, odd_chan_sel_bit0;
    logic [1:0] even_chan_sel_bit1, even_chan_sel_bit0;
    logic odd_group_ff, upper_group_ff, selection_valid_ff;
    logic [1:0] chan_xlat, func_xlat;
    int error_cnt = 0, check_count = 0, cyc_cnt = 0;

    iops_select uut (.*);
    iops_periph per (.*);

    // 200 MHz clock
    initial
    begin
        forever #2.5 clk_sys = ~clk_sys;
    end

    task automatic end_of_test;
        $display("checks %0d errors %0d", check_count, error_cnt);
        if (error_cnt == 0 && check_count > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask

    // Hang guard, far above the few hundred cycles needed
    always @(posedge clk_sys)
    begin
        cyc_cnt++;
        if (cyc_cnt == 8000)
        begin
            error_cnt++;
            end_of_test();
        end
    end

    task automatic chk(input string n, input logic [31:0] s, e);
        check_count++;
        if (s !== e)
        begin
            error_cnt++;
            $display("wrong value %s exp %h got %h", n, e, s);
        end
    endtask

    task automatic cyc(input int n);
        repeat (n) @(posedge clk_sys);
    endtask

    // One-cycle strobe: 0 data scan, 1 intr scan, 2 gate, 3 clear
    task automatic pul(input int k);
        {xlat_clear, req_gate, intr_scan, data_scan} <= 4'h1 << k;
        @(posedge clk_sys);
        {xlat_clear, req_gate, intr_scan, data_scan} <= 4'h0;
    endtask

    task automatic ack(input logic [7:0] a);
        {id_ack, od_ef_ack} <= a;
        @(posedge clk_sys);
        {id_ack, od_ef_ack} <= 8'h00;
    endtask

    // Idle edge first, so back-to-back calls never reassign psel
    task automatic apb(input logic w, input logic [11:0] a,
                       input logic [31:0] d);
        @(posedge clk_sys);
        {psel, pwrite, paddr, pwdata} <= {1'h1, w, a, d};
        @(posedge clk_sys);
        penable <= 1'h1;
        @(posedge clk_sys);
        while (pready !== 1'h1)
            @(posedge clk_sys);
        rd = prdata;
        er = pslverr;
        {psel, penable} <= 2'h0;
    endtask

    // Clear, post requests, let them sync, then scan
    task automatic load(input logic [63:0] v, input int k);
        pul(3);
        per.post(v);
        cyc(3);
        pul(k);
        cyc(2);
    endtask

    task automatic t_regs;
        apb(1'h0, IOPS_CTRL_OFS, 32'h0);
        chk("ctrl", rd, 32'(IOPS_CTRL_RST));
        apb(1'h0, 12'h00c, 32'h0);
        chk("unmapped", er, 1'h1);
        apb(1'h1, IOPS_CTRL_OFS, 32'h0);
        load(64'h0000_0100_0000_0000, 0);
        chk("disabled", chassis_request_present, 4'h0);
        apb(1'h1, IOPS_CTRL_OFS, 32'h1);
    endtask

    task automatic t_chan;
        logic [7:0] m;
        logic [1:0] e;
        for (int c = 0; c < 8; c++)
        begin
            m = 8'((16'h2 << c) - 16'h1);
            e = 2'(c >> 1);
            load({16'h0, m, 40'h0}, 0);
            chk("pres", chassis_request_present, c[0] ? 4'h1 : 4'h2);
            chk("any", any_request_present, 1'h1);
            chk("odd", {odd_chan_sel_bit1[0], odd_chan_sel_bit0[0]},
                c[0] ? e : 2'h0);
            chk("even", {even_chan_sel_bit1[0], even_chan_sel_bit0[0]},
                c[0] ? 2'h0 : e);
        end
        // Last grant was channel 7 of drawer 0
        apb(1'h0, IOPS_CHAN_OFS, 32'h0);
        chk("chan reg", rd, 32'h0000_0080);
    endtask

    task automatic t_func;
        logic [63:0] v [7] = '{64'h0800_0000_0000_0000,
            64'h0008_0808_0000_0000, 64'h0000_0800_0000_0000,
            64'h0000_0008_0000_0000, 64'h0000_0808_0000_0000,
            64'h0000_0808_0000_0000, 64'h0000_0808_0000_0000};
        logic [1:0] e [7] = '{IOPS_TYPE_EI, IOPS_TYPE_EF, IOPS_TYPE_OD,
            IOPS_TYPE_ID, IOPS_TYPE_OD, IOPS_TYPE_ID, IOPS_TYPE_OD};
        logic [1:0] t;
        for (int i = 0; i < 7; i++)
        begin
            if (i == 5)
                ack(8'h01);
            if (i == 6)
                ack(8'h10);
            load(v[i], int'(i == 0));
            t = {function_type_hi_out[0], function_type_lo_out[0]};
            chk("fn", t, e[i]);
            chk("fpres", chassis_request_present, 4'h1);
        end
        // Alternator set by acknowledge, then cleared from control
        ack(8'h01);
        apb(1'h0, IOPS_STATUS_OFS, 32'h0);
        chk("alt set", rd[IOPS_ST_ALT_LSB +: 4], 4'h1);
        apb(1'h1, IOPS_CTRL_OFS, 32'h3);
        apb(1'h0, IOPS_STATUS_OFS, 32'h0);
        chk("alt clr", rd[IOPS_ST_ALT_LSB +: 4], 4'h0);
        apb(1'h1, IOPS_CTRL_OFS, 32'h1);
    endtask

    task automatic t_group;
        logic [15:0] r [6] = '{16'h0200, 16'h0100, 16'h0804, 16'h0020,
            16'h8001, 16'h0060};
        logic [3:0] x [6] = '{4'h4, 4'h0, 4'h9, 4'he, 4'h8, 4'hb};
        logic [3:0] u [6] = '{4'h0, 4'h0, 4'h1, 4'h8, 4'h0, 4'h3};
        for (int i = 0; i < 6; i++)
        begin
            load({16'h0, r[i][15:8], 24'h0, r[i][7:0], 8'h0}, 0);
            pul(2);
            per.post(64'h0);
            cyc(4);
            chk("valid", selection_valid_ff, 1'h1);
            chk("grp", {upper_group_ff, odd_group_ff, chan_xlat}, x[i]);
            chk("func", func_xlat, IOPS_TYPE_OD);
            chk("dec", group_decode, 4'h1 << x[i][3:2]);
            chk("d1 enc", {odd_chan_sel_bit1[1], odd_chan_sel_bit0[1],
                even_chan_sel_bit1[1], even_chan_sel_bit0[1]}, u[i]);
            apb(1'h0, IOPS_STATUS_OFS, 32'h0);
            chk("status", rd[IOPS_ST_VALID_BIT], 1'h1);
            pul(3);
            cyc(2);
            chk("dec off", group_decode, 4'h0);
        end
    endtask

    // Reset for 12 cycles, then the scenarios in turn
    initial
    begin
        cyc(12);
        resetn <= 1'h1;
        cyc(2);
        t_regs();
        t_chan();
        t_func();
        t_group();
        end_of_test();
    end
endmodule // iops_select_test
`default_nettype wire
